// ==== verilog/system_control_regs.sv ====
// System control register bank: keyed reset control, low-power control, config info.
// Assumes an AHB-Lite master on hclk; core sideband signals on hclk.
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "sysctl_defs.svh"

// Notes on behaviour
// (R1) Interrupt/reset control writes apply only with key 0x05fa in bits 31:16.
// (R2) Writing one to reset-request with valid key requests system reset; reads zero.
// (R3) Software must write zero to debug active-clear bit; it reads zero.
// (R4) Event-on-pending zero: enabled sources wake; one: all interrupts wake.
// (R5) Pending events wake a waiting core, else are latched for next wait.
// (R6) The send-event instruction also wakes the core from wait-for-event.
// (R7) Deep-sleep select chooses ordinary sleep (0) or deep sleep (1).
// (R8) Sleep-on-exit makes the core sleep on return to thread mode.
// (R9) Stack-alignment flag always reads one: eight-byte aligned exception stacks.
// (R10) Entry records alignment in stacked status bit nine; return restores it.
// (R11) Unaligned-trap flag reads one; every unaligned access raises hard fault.
// (R12) Configuration register is read-only; writes change nothing.
// (R13) Byte order flag, bit fifteen, reports endianness and ignores writes.
// (R14) Reserved bits read zero and ignore writes.
module system_control_regs
    import sysctl_pkg::*;
#(
    parameter logic BIG_ENDIAN = 1'b0
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire wake_in_t    wake_in,
    input  wire logic        handler_return,
    input  wire logic        exc_entry,
    input  wire logic        exc_return,
    input  wire logic        sp_bit2,
    input  wire logic        stacked_psr_align,
    input  wire logic        unaligned_access,
    output logic             sys_reset_req,
    output logic             sleep_req,
    output logic             deep_sleep_req,
    output logic             wake_now,
    output logic             event_latched,
    output logic             psr_align_bit,
    output logic             sp_realign,
    output logic             hard_fault_req
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                     wr_pend;
        logic [`ADDR_BITS-1:0]    wr_addr;
        logic [31:0]              rdata;
        low_power_t               lp;
        logic [2:0]               rst_cnt;
        logic                     rst_req;
        pwr_state_t               pwr;
        logic                     psr_align;
        logic                     realign;
        logic                     fault;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic     addr_phase;
    logic     key_ok;
    logic     word_ok;
    logic     waiting;
    logic     wake_int;
    logic     latched_int;
    wake_in_t wake_eff;

    ////////////////////////////////////////////////////////////////////////////////
    // Field helpers

    // Only aligned whole words reach the registers; narrower writes are dropped
    function automatic logic word_access(input logic [2:0] size,
                                         input logic [1:0] low);
        return (size == 3'h2) && (low == 2'h0);
    endfunction

    function automatic logic key_match(input logic [31:0] w);
        return w[`KEY_HI:`KEY_LO] == `WRITE_KEY_VALUE; // R1
    endfunction

    function automatic logic [31:0] app_int_rst_word();
        logic [31:0] v;
        v                  = 32'h0000_0000; // R14
        // The key field reads as zero rather than a random value
        v[`BYTE_ORDER_POS] = BIG_ENDIAN;    // R13
        v[`RESET_REQ_POS]  = 1'b0;          // R2
        v[`DBG_CLR_POS]    = 1'b0;          // R3
        return v;
    endfunction

    function automatic logic [31:0] low_power_word(input low_power_t lp);
        logic [31:0] v;
        v                    = 32'h0000_0000; // R14
        v[`EVT_ON_PEND_POS]  = lp.evt_on_pend;
        v[`DEEP_SLEEP_POS]   = lp.deep_sleep;
        v[`SLEEP_ON_RET_POS] = lp.sleep_on_ret;
        return v;
    endfunction

    function automatic low_power_t low_power_fields(input logic [31:0] w);
        low_power_t lp;
        lp.evt_on_pend  = w[`EVT_ON_PEND_POS];  // R4
        lp.deep_sleep   = w[`DEEP_SLEEP_POS];   // R7
        lp.sleep_on_ret = w[`SLEEP_ON_RET_POS]; // R8
        return lp;
    endfunction

    function automatic logic [31:0] core_config_word();
        logic [31:0] v;
        v                    = 32'h0000_0000; // R14
        v[`STACK_ALIGN_POS]  = 1'b1; // R9
        v[`UNALIGN_TRAP_POS] = 1'b1; // R11
        return v;
    endfunction

    function automatic logic in_low_power(input pwr_state_t p);
        return p != PWR_RUN;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Read value of a register at a word offset

    function automatic logic [31:0] read_word(input logic [`ADDR_BITS-1:0] a,
                                              input low_power_t lp);
        logic [31:0] v;
        v = 32'h0000_0000; // R14
        case (a)
            `OFF_APP_INT_RST: v = app_int_rst_word(); // R1 R2 R3 R13
            `OFF_LOW_POWER:   v = low_power_word(lp);
            `OFF_CORE_CONFIG: v = core_config_word(); // R9 R11
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Wait-for-event latch

    wake_event_latch u_wake (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .evt_on_pend (st_q.lp.evt_on_pend),
        .wake_in     (wake_eff),
        .wake_now    (wake_int),
        .latched     (latched_int)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    assign addr_phase = hsel & hready & htrans[1];
    assign word_ok    = word_access(hsize, haddr[1:0]);
    assign key_ok     = key_match(hwdata);
    // A waiting core consumes a new event at once instead of latching it
    assign waiting    = (st_q.pwr == PWR_WAIT_EVT); // R5
    assign wake_eff   = {wake_in.wfe_exec | waiting, wake_in.sev_exec, wake_in.irq_pending_any,
                         wake_in.irq_pending_en, wake_in.event_in};

    always_comb begin
        st_d         = st_q;
        st_d.wr_pend = 1'b0;
        st_d.fault   = unaligned_access; // R11
        st_d.realign = 1'b0;

        if (addr_phase) begin
            st_d.wr_pend = hwrite & word_ok;
            st_d.wr_addr = haddr[`ADDR_BITS-1:0];
        end

        // Write data arrive one cycle after the address phase
        if (st_q.wr_pend) begin
            case (st_q.wr_addr)
                `OFF_APP_INT_RST: begin
                    // A wrong key drops the whole word
                    if (key_ok && hwdata[`RESET_REQ_POS]) begin // R1
                        st_d.rst_req = 1'b1; // R2
                        st_d.rst_cnt = 3'(`RESET_PULSE_CYC);
                    end
                end
                `OFF_LOW_POWER: begin
                    st_d.lp = low_power_fields(hwdata); // R14
                end
                default: begin
                    // Configuration word and unmapped offsets take no write
                    st_d.lp = st_q.lp; // R12
                end
            endcase
        end

        // Read data use the updated control word, so a read right behind a write sees it
        if (addr_phase) begin
            st_d.rdata = read_word(haddr[`ADDR_BITS-1:0], st_d.lp);
        end

        // Reset request is held a few cycles so slow reset logic catches it
        if (st_q.rst_req) begin
            if (st_q.rst_cnt == 3'h1) begin
                st_d.rst_req = 1'b0;
            end
            st_d.rst_cnt = st_q.rst_cnt - 3'h1;
        end

        // Exception stacking keeps eight-byte alignment
        if (exc_entry) begin
            st_d.psr_align = sp_bit2; // R10
        end
        if (exc_return) begin
            st_d.realign = stacked_psr_align; // R10
        end

        case (st_q.pwr)
            PWR_RUN: begin
                if (wake_in.wfe_exec && !latched_int) begin
                    st_d.pwr = PWR_WAIT_EVT;
                end else if (handler_return && st_q.lp.sleep_on_ret) begin
                    st_d.pwr = PWR_SLEEP; // R8
                end
            end
            PWR_WAIT_EVT: begin
                if (wake_int) begin
                    st_d.pwr = PWR_RUN; // R5 R6
                end
            end
            PWR_SLEEP: begin
                if (wake_in.irq_pending_en) begin
                    st_d.pwr = PWR_RUN;
                end
            end
            default: st_d.pwr = PWR_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q           <= '0;
            st_q.lp        <= `LOW_POWER_RESET;
            st_q.pwr       <= PWR_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = st_q.rdata;
    assign sys_reset_req  = st_q.rst_req;
    assign sleep_req      = in_low_power(st_q.pwr) & ~st_q.lp.deep_sleep; // R7
    assign deep_sleep_req = in_low_power(st_q.pwr) & st_q.lp.deep_sleep;  // R7
    assign wake_now       = wake_int;
    assign event_latched  = latched_int;
    assign psr_align_bit  = st_q.psr_align;
    assign sp_realign     = st_q.realign;
    assign hard_fault_req = st_q.fault;

endmodule

// ==== verilog/sysctl_defs.svh ====
// Offsets, field positions, reset values and timing counts of the system control registers.
// Assumes inclusion by the package and by the design modules.
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

`define OFF_APP_INT_RST     12'h00c
`define OFF_LOW_POWER       12'h010
`define OFF_CORE_CONFIG     12'h014
`define ADDR_BITS           12

`define WRITE_KEY_VALUE     16'h05fa
`define KEY_HI              31
`define KEY_LO              16
`define BYTE_ORDER_POS      15
`define RESET_REQ_POS       2
`define DBG_CLR_POS         1
`define EVT_ON_PEND_POS     4
`define DEEP_SLEEP_POS      2
`define SLEEP_ON_RET_POS    1
`define STACK_ALIGN_POS     9
`define UNALIGN_TRAP_POS    3
`define PSR_ALIGN_POS       9

`define LOW_POWER_RESET     3'h0
`define RESET_PULSE_NS      100
`define CLK_PERIOD_NS       25
`define RESET_PULSE_CYC     ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== verilog/sysctl_pkg.sv ====
// Types shared by the system control register bank and its wake logic.
// Assumes the constants header lives beside it.
`include "sysctl_defs.svh"

package sysctl_pkg;

    typedef struct packed {
        logic evt_on_pend;
        logic deep_sleep;
        logic sleep_on_ret;
    } low_power_t;

    typedef struct packed {
        logic wfe_exec;
        logic sev_exec;
        logic irq_pending_any;
        logic irq_pending_en;
        logic event_in;
    } wake_in_t;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_WAIT_EVT,
        PWR_SLEEP
    } pwr_state_t;

endpackage

// ==== verilog/wake_event_latch.sv ====
// Event latch and wake decision for wait-for-event.
// Assumes all inputs come from core logic on hclk.
`timescale 1ns/1ps

module wake_event_latch
    import sysctl_pkg::*;
(
    input  wire logic     hclk,
    input  wire logic     hresetn,
    input  wire logic     evt_on_pend,
    input  wire wake_in_t wake_in,
    output logic          wake_now,
    output logic          latched
);

    typedef struct packed {
        logic latch;
        logic wake;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic   pend_evt;
    logic   ev;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d     = st_q;
        // Disabled interrupts count only with send-event-on-pending set
        pend_evt = wake_in.irq_pending_en | (evt_on_pend & wake_in.irq_pending_any); // R4
        ev       = pend_evt | wake_in.event_in | wake_in.sev_exec; // R5 R6
        st_d.wake = 1'b0;
        if (wake_in.wfe_exec) begin
            if (st_q.latch || ev) begin
                st_d.wake  = 1'b1; // R5
                st_d.latch = 1'b0;
            end
        end else if (ev) begin
            st_d.latch = 1'b1; // R5
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign wake_now = st_q.wake;
    assign latched  = st_q.latch;

endmodule

// ==== tb/sysctl_chk_assertions.sv ====
// Assertion checker for the system control register bank.
// Assumes single-word transfers; bound to the bank at the foot of this file.
`timescale 1ns/1ps
`include "sysctl_defs.svh"
module sysctl_chk
    import sysctl_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire wake_in_t    wake_in,
    input wire logic        unaligned_access,
    input wire logic        sys_reset_req,
    input wire logic        sleep_req,
    input wire logic        deep_sleep_req,
    input wire logic        wake_now,
    input wire logic        hard_fault_req
);
    // Valid, write and offset of the address phase, seen during the data phase
    logic [13:0] ph_q;
    logic        aic_w, aic_r, cfg_r, key_ok;
    assign aic_w = ph_q[13:12] == 2'h3 && ph_q[11:0] == `OFF_APP_INT_RST;
    assign aic_r = ph_q[13:12] == 2'h2 && ph_q[11:0] == `OFF_APP_INT_RST;
    assign cfg_r = ph_q[13:12] == 2'h2 && ph_q[11:0] == `OFF_CORE_CONFIG;
    assign key_ok = hwdata[31:16] == `WRITE_KEY_VALUE;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 14'h0000;
        end else begin
            ph_q <= {hsel && hready && htrans[1], hwrite, haddr[11:0]};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    a_key_reset: assert property (aic_w && key_ok && hwdata[2] && !sys_reset_req
        |=> sys_reset_req [*4] ##1 !sys_reset_req) else $error("reset pulse wrong");
    a_bad_key: assert property (aic_w && !key_ok && !sys_reset_req |=> !sys_reset_req)
        else $error("unkeyed write acted");
    a_cfg_fixed: assert property (cfg_r |-> hrdata == 32'h0000_0208)
        else $error("config read wrong");
    a_ctrl_read: assert property (aic_r |-> hrdata == 32'h0000_0000)
        else $error("reset ctrl read wrong");
    a_hard_fault: assert property (unaligned_access |=> hard_fault_req)
        else $error("no hard fault");
    a_sev_wake: assert property (wake_in.wfe_exec && wake_in.sev_exec |=> wake_now)
        else $error("send event did not wake");
    a_enabled_wake: assert property (wake_in.wfe_exec && wake_in.irq_pending_en |=> wake_now)
        else $error("enabled irq did not wake");
    a_wake_cause: assert property ($rose(wake_now)
        |-> $past(wake_in.wfe_exec | sleep_req | deep_sleep_req))
        else $error("wake without wait");
    cover property (sys_reset_req);
    cover property (wake_now);
    cover property (hard_fault_req);
endmodule

bind system_control_regs sysctl_chk regs_chk (.*);

// ==== tb/system_control_regs_tb_top.sv ====
// Self-checking bench for the system control register bank.
// Assumes the bound checker is compiled in; hready is looped back from the slave.
`timescale 1ns/1ps
`include "sysctl_defs.svh"
module system_control_regs_tb_top
    import sysctl_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        handler_return = 1'b0, exc_entry = 1'b0, exc_return = 1'b0;
    logic        unaligned_access = 1'b0, sp_bit2 = 1'b0, stacked_psr_align = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    wake_in_t    wake_in = 5'h00;
    wire logic   hready;
    logic        hreadyout, hresp, sys_reset_req, sleep_req, deep_sleep_req, wake_now;
    logic        event_latched, psr_align_bit, sp_realign, hard_fault_req;
    int          bad_count = 0, cmp_count = 0;

    system_control_regs dut (.*);
    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;
    ////////////////////////////////////////
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask

    // A slave that never raises ready ends the run here
    task automatic wait_rdy();
        for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (hready === 1'b1) return;
        end
        bad_count++;
        summarize();
    endtask

    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h00000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rchk(string n, logic [11:0] a, logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(n, rd, e);
    endtask

    task automatic rst_cycles();
        rd = 32'h0000_0000;
        repeat (8) begin
            @(negedge hclk);
            rd = rd + sys_reset_req;
        end
    endtask

    // Core sideband pulses last one cycle; outputs are judged at the following low phase
    task automatic pulse(wake_in_t w, logic [3:0] p);
        @(posedge hclk);
        wake_in <= w;
        {handler_return, exc_entry, exc_return, unaligned_access} <= p;
        @(posedge hclk);
        wake_in <= 5'h00;
        {handler_return, exc_entry, exc_return, unaligned_access} <= 4'h0;
        @(negedge hclk);
    endtask
    ////////////////////////////////////////
    task automatic s_config();
        rchk("config", `OFF_CORE_CONFIG, 32'h0000_0208);
        xfer(1'b1, `OFF_CORE_CONFIG, 32'hffff_ffff);
        rchk("config kept", `OFF_CORE_CONFIG, 32'h0000_0208);
        rchk("unmapped", 12'h040, 32'h0000_0000);
    endtask

    task automatic s_reset_ctrl();
        xfer(1'b1, `OFF_APP_INT_RST, 32'h05fa_fff9);
        rchk("reset ctrl", `OFF_APP_INT_RST, 32'h0000_0000);
        xfer(1'b1, `OFF_APP_INT_RST, 32'h05fb_0004);
        rst_cycles();
        chk("bad key", rd, 32'h0000_0000);
        xfer(1'b1, `OFF_APP_INT_RST, 32'h05fa_0004);
        rst_cycles();
        chk("reset pulse", rd, 32'h0000_0004);
        rchk("request bit", `OFF_APP_INT_RST, 32'h0000_0000);
    endtask

    task automatic s_sleep();
        xfer(1'b1, `OFF_LOW_POWER, 32'hffff_ffff);
        rchk("low power", `OFF_LOW_POWER, 32'h0000_0016);
        xfer(1'b1, `OFF_LOW_POWER, 32'h0000_0000);
        pulse(5'h00, 4'h8);
        chk("no exit sleep", sleep_req, 1'b0);
        xfer(1'b1, `OFF_LOW_POWER, 32'h0000_0002);
        pulse(5'h00, 4'h8);
        chk("exit sleep", {sleep_req, deep_sleep_req}, 2'h2);
        pulse(5'h02, 4'h0);
        xfer(1'b1, `OFF_LOW_POWER, 32'h0000_0006);
        pulse(5'h00, 4'h8);
        chk("deep sleep", deep_sleep_req, 1'b1);
        pulse(5'h02, 4'h0);
    endtask

    task automatic s_wake();
        xfer(1'b1, `OFF_LOW_POWER, 32'h0000_0000);
        pulse(5'h10, 4'h0);
        chk("latch consumed", event_latched, 1'b0);
        pulse(5'h01, 4'h0);
        chk("latched", event_latched, 1'b1);
        pulse(5'h10, 4'h0);
        chk("latched wake", wake_now, 1'b1);
        pulse(5'h14, 4'h0);
        chk("disabled irq", wake_now, 1'b0);
        pulse(5'h01, 4'h0);
        chk("event wakes wait", wake_now, 1'b1);
        chk("event consumed", event_latched, 1'b0);
        pulse(5'h18, 4'h0);
        chk("send event", wake_now, 1'b1);
        xfer(1'b1, `OFF_LOW_POWER, 32'h0000_0010);
        pulse(5'h14, 4'h0);
        chk("any irq", wake_now, 1'b1);
    endtask

    task automatic s_exc();
        @(posedge hclk);
        sp_bit2 <= 1'b1;
        stacked_psr_align <= 1'b1;
        pulse(5'h00, 4'h4);
        chk("stacked align", psr_align_bit, 1'b1);
        pulse(5'h00, 4'h2);
        chk("realign", sp_realign, 1'b1);
        pulse(5'h00, 4'h1);
        chk("hard fault", hard_fault_req, 1'b1);
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        s_config();
        s_reset_ctrl();
        s_sleep();
        s_wake();
        s_exc();
        summarize();
    end
endmodule
